//--- logic/srg_delay_map.sv
// maps the delay code onto the four delay words
`timescale 1ns/1ns
module srg_delay_map
   import srg_pkg::*;
(
   input  wire logic [7:0]        code_in,
   output srg_pkg::srg_dac_t      dac_out,
   output logic                   valid_out
);

   logic [8:0] pos;
   logic [2:0] seg;
   logic [1:0] hi_idx;
   logic [5:0] w [4];

   // ------------------------------------------------------------
   // slide 63 between adjacent words
   // ------------------------------------------------------------
   always_comb begin
      pos = {1'b0, code_in} + DELAY_OFFSET;
      seg = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (pos >= DAC_SPAN) begin
            pos = pos - DAC_SPAN;
            seg = seg + 3'h1;
         end
      end
      hi_idx = seg[1:0] + 2'h1;
      for (int j = 0; j < 4; j++) begin
         w[j] = 6'h00;
      end
      w[seg[1:0]] = DAC_SUM - pos[5:0];
      w[hi_idx]   = pos[5:0];
      dac_out     = '{dac4: w[3], dac3: w[2], dac2: w[1], dac1: w[0]};
      valid_out   = (code_in <= DELAY_MAX);
   end

endmodule : srg_delay_map

//--- logic/srg_pkg.sv
// constants, field layout and carrier types of the ref_pulsed_select generator
package srg_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_PERIOD     = 8'h01;
   localparam logic [7:0]  ADDR_DELAY      = 8'h02;
   localparam logic [7:0]  ADDR_ROUTE      = 8'h03;
   localparam logic [7:0]  ADDR_STATUS     = 8'h04;
   localparam logic [7:0]  ADDR_DAC_LO     = 8'h05;
   localparam logic [7:0]  ADDR_DAC_HI     = 8'h06;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int          CTRL_EN_BIT     = 0;
   localparam int          CTRL_RPT_BIT    = 1;
   localparam int          CTRL_PULSED_BIT = 2;
   localparam int          CTRL_CNT_LSB    = 4;
   localparam int          CTRL_PRE_LSB    = 8;
   localparam int          ROUTE_A_LSB     = 0;
   localparam int          ROUTE_B_LSB     = 2;
   localparam int          ROUTE_SEG_LSB   = 4;
   localparam int          ROUTE_TWO_BIT   = 8;

   // ------------------------------------------------------------
   // reset values and codes
   // ------------------------------------------------------------
   localparam logic [3:0]  PULSE_CNT_RST   = 4'h4;
   localparam logic [2:0]  PREDIV_RST      = 3'h1;
   localparam logic [10:0] PERIOD_RST      = 11'h000;
   localparam logic [7:0]  DELAY_RST       = 8'h00;
   localparam logic [1:0]  SEL_CHDIV       = 2'h0;
   localparam logic [1:0]  SEL_VCO         = 2'h1;
   localparam logic [1:0]  SEL_SYSREF      = 2'h2;
   localparam logic [7:0]  DELAY_MAX       = 8'hF7;
   localparam logic [8:0]  DELAY_OFFSET    = 9'h01B;
   localparam logic [8:0]  DAC_SPAN        = 9'h03F;
   localparam logic [5:0]  DAC_SUM         = 6'h3F;
   localparam logic [5:0]  DAC1_RST        = 6'h24;
   localparam logic [5:0]  DAC2_RST        = 6'h1B;
   localparam logic [12:0] MASTER_BASE     = 13'h0004;
   localparam logic [12:0] RPT_BASE        = 13'h0002;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } srg_bus_t;

   typedef struct packed {
      logic [5:0] dac4;
      logic [5:0] dac3;
      logic [5:0] dac2;
      logic [5:0] dac1;
   } srg_dac_t;

   typedef struct packed {
      logic        en;
      logic        repeater;
      logic        pulsed;
      logic [3:0]  pulse_cnt;
      logic [2:0]  prediv;
      logic [10:0] period;
      logic [7:0]  delay;
      logic [1:0]  out_a_sel;
      logic [1:0]  out_b_sel;
      logic [3:0]  seg1;
      logic        chdiv_two;
   } srg_cfg_t;

endpackage : srg_pkg

//--- logic/srg_sysref_gen.sv
// ref_pulsed_select generator: dividers, request re-clocking, pulse engine, delay words
`timescale 1ns/1ns
module srg_sysref_gen
   import srg_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              sys_rst_in,
   input  wire srg_pkg::srg_bus_t bus_in,
   output logic [15:0]            bus_rdata_out,
   input  wire logic              ref_request_pin_in,
   output logic                   out_b_pin_p_out,
   output logic                   out_b_pin_n_out,
   output srg_pkg::srg_dac_t      delay_dac_out,
   output logic                   cfg_error_out
);

   typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} srg_state_t;

   srg_cfg_t   cfg_q;
   srg_state_t state_q;
   srg_dac_t   map_dac;
   logic       map_valid;
   logic [7:0] incl_div;
   logic [15:0] total_prod;
   logic [7:0] total_div;
   logic       prediv_ok;
   logic       div_ok;
   logic [7:0] icnt_q;
   logic [7:0] ocnt_q;
   logic       interp_tick;
   logic       out_tick;
   logic       req_q;
   logic       req_prev_q;
   logic       edge_evt;
   logic       pend_q;
   logic       step;
   logic       start;
   logic [12:0] half_end;
   logic [12:0] half_q;
   logic       half_done;
   logic [3:0] rem_q;
   logic       out_d;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [7:0] included_divide(input srg_cfg_t c);
      if (c.out_a_sel != SEL_CHDIV && c.out_b_sel != SEL_CHDIV && c.out_b_sel != SEL_SYSREF) begin
         return 8'h01;
      end else if (c.chdiv_two) begin
         return 8'h04;
      end else begin
         return {3'h0, c.seg1, 1'b0};
      end
   endfunction : included_divide

   function automatic logic hit(input logic [7:0] cnt, input logic [7:0] lim);
      return (cnt == lim - 8'h01);
   endfunction : hit

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cfg_q <= '{en: 1'b0, repeater: 1'b0, pulsed: 1'b0, pulse_cnt: PULSE_CNT_RST,
                    prediv: PREDIV_RST, period: PERIOD_RST, delay: DELAY_RST,
                    out_a_sel: SEL_VCO, out_b_sel: SEL_VCO, seg1: 4'h1, chdiv_two: 1'b0};
      end else if (bus_in.wr) begin
         unique case (bus_in.addr)
            ADDR_CTRL: begin
               cfg_q.en        <= bus_in.wdata[CTRL_EN_BIT];
               cfg_q.repeater  <= bus_in.wdata[CTRL_RPT_BIT];
               cfg_q.pulsed    <= bus_in.wdata[CTRL_PULSED_BIT];
               cfg_q.pulse_cnt <= bus_in.wdata[CTRL_CNT_LSB +: 4];
               cfg_q.prediv    <= bus_in.wdata[CTRL_PRE_LSB +: 3];
            end
            ADDR_PERIOD: cfg_q.period <= bus_in.wdata[10:0];
            ADDR_DELAY:  cfg_q.delay  <= bus_in.wdata[7:0];
            ADDR_ROUTE: begin
               cfg_q.out_a_sel <= bus_in.wdata[ROUTE_A_LSB +: 2];
               cfg_q.out_b_sel <= bus_in.wdata[ROUTE_B_LSB +: 2];
               cfg_q.seg1      <= bus_in.wdata[ROUTE_SEG_LSB +: 4];
               cfg_q.chdiv_two <= bus_in.wdata[ROUTE_TWO_BIT];
            end
            default: ;
         endcase
      end
   end

   // read data stand for one cycle per cycle of bus_in.rd, zero otherwise
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !bus_in.rd) begin
         bus_rdata_out <= 16'h0000;
      end else begin
         unique case (bus_in.addr)
            ADDR_CTRL:   bus_rdata_out <= {5'h00, cfg_q.prediv, cfg_q.pulse_cnt, 1'b0,
                                           cfg_q.pulsed, cfg_q.repeater, cfg_q.en};
            ADDR_PERIOD: bus_rdata_out <= {5'h00, cfg_q.period};
            ADDR_DELAY:  bus_rdata_out <= {8'h00, cfg_q.delay};
            ADDR_ROUTE:  bus_rdata_out <= {7'h00, cfg_q.chdiv_two, cfg_q.seg1,
                                           cfg_q.out_b_sel, cfg_q.out_a_sel};
            ADDR_STATUS: bus_rdata_out <= {7'h00, req_q, rem_q, 1'b0, cfg_error_out,
                                           (state_q != ST_IDLE), out_b_pin_p_out};
            ADDR_DAC_LO: bus_rdata_out <= {4'h0, delay_dac_out.dac2, delay_dac_out.dac1};
            ADDR_DAC_HI: bus_rdata_out <= {4'h0, delay_dac_out.dac4, delay_dac_out.dac3};
            default:     bus_rdata_out <= 16'h0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // delay words
   // ------------------------------------------------------------
   srg_delay_map u_map (
      .code_in   (cfg_q.delay),
      .dac_out   (map_dac),
      .valid_out (map_valid)
   );

   // an invalid code leaves the last legal words in place, so the sum stays 63
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         delay_dac_out <= '{dac4: 6'h00, dac3: 6'h00, dac2: DAC2_RST, dac1: DAC1_RST};
      end else if (map_valid) begin
         delay_dac_out <= map_dac;
      end
   end

   // ------------------------------------------------------------
   // interpolator and output clock enables
   // ------------------------------------------------------------
   assign incl_div   = included_divide(cfg_q);
   assign total_prod = incl_div * {5'h00, cfg_q.prediv};
   assign total_div  = total_prod[7:0];
   assign prediv_ok  = (cfg_q.prediv == 3'h1) || (cfg_q.prediv == 3'h2) || (cfg_q.prediv == 3'h4);
   assign div_ok     = prediv_ok && (incl_div != 8'h00);
   assign interp_tick = div_ok && hit(icnt_q, total_div);
   assign out_tick    = div_ok && hit(ocnt_q, incl_div);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || interp_tick || !div_ok || icnt_q >= total_div) begin
         icnt_q <= 8'h00;
      end else begin
         icnt_q <= icnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || out_tick || !div_ok || ocnt_q >= incl_div) begin
         ocnt_q <= 8'h00;
      end else begin
         ocnt_q <= ocnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cfg_error_out <= 1'b0;
      end else begin
         cfg_error_out <= !div_ok || !map_valid;
      end
   end

   // ------------------------------------------------------------
   // request re-clocking
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         req_q      <= 1'b0;
         req_prev_q <= 1'b0;
      end else if (interp_tick) begin
         req_q      <= ref_request_pin_in;
         req_prev_q <= req_q;
      end
   end

   assign edge_evt = interp_tick && (req_q != req_prev_q);

   // edge waits for the next output-clock enable; a new edge wins over the clear
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !cfg_q.en) begin
         pend_q <= 1'b0;
      end else if (edge_evt) begin
         pend_q <= 1'b1;
      end else if (out_tick) begin
         pend_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // pulse engine
   // ------------------------------------------------------------
   assign step     = cfg_q.repeater ? out_tick : interp_tick;
   assign half_end = cfg_q.repeater ? RPT_BASE + {2'h0, cfg_q.period}
                                    : MASTER_BASE + {1'b0, cfg_q.period, 1'b0};
   assign half_done = step && (half_q >= half_end - 13'h0001);

   always_comb begin
      if (!cfg_q.en || (cfg_q.pulsed && cfg_q.pulse_cnt == 4'h0)) begin
         start = 1'b0;
      end else if (cfg_q.repeater) begin
         start = out_tick && pend_q;
      end else if (cfg_q.pulsed) begin
         start = edge_evt && req_q;
      end else begin
         start = (state_q == ST_IDLE);
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !cfg_q.en) begin
         state_q <= ST_IDLE;
         half_q  <= 13'h0000;
         rem_q   <= 4'h0;
      end else if (start) begin
         state_q <= ST_HIGH;
         half_q  <= 13'h0000;
         rem_q   <= cfg_q.pulse_cnt;
      end else begin
         unique case (state_q)
            ST_IDLE: half_q <= 13'h0000;
            ST_HIGH: begin
               if (half_done) begin
                  state_q <= ST_LOW;
                  half_q  <= 13'h0000;
               end else if (step) begin
                  half_q <= half_q + 13'h0001;
               end
            end
            ST_LOW: begin
               if (half_done) begin
                  half_q <= 13'h0000;
                  if (cfg_q.pulsed && rem_q <= 4'h1) begin
                     state_q <= ST_IDLE;
                     rem_q   <= 4'h0;
                  end else begin
                     state_q <= ST_HIGH;
                     rem_q   <= cfg_q.pulsed ? rem_q - 4'h1 : rem_q;
                  end
               end else if (step) begin
                  half_q <= half_q + 13'h0001;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // differential output
   // ------------------------------------------------------------
   // master pulses pass only while the re-clocked request stays high
   assign out_d = (state_q == ST_HIGH) && cfg_q.en && (cfg_q.repeater || req_q);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         out_b_pin_p_out <= 1'b0;
         out_b_pin_n_out <= 1'b1;
      end else begin
         out_b_pin_p_out <= out_d;
         out_b_pin_n_out <= !out_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_idle_rpt;
      (state_q == ST_IDLE) && cfg_q.repeater && cfg_q.en;
   endsequence

   sequence s_enter_high;
      ##1 (state_q == ST_HIGH);
   endsequence

   chk_prediv_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !prediv_ok |-> !interp_tick) else $error("interpolator ticks with illegal predivider");
   chk_incl_one: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (cfg_q.out_a_sel == SEL_VCO && cfg_q.out_b_sel == SEL_VCO) |-> incl_div == 8'h01)
      else $error("included divide not one");
   chk_req_sample: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      interp_tick |=> req_q == $past(ref_request_pin_in)) else $error("request not re-clocked");
   chk_master_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (!cfg_q.repeater && !req_q) |=> !out_b_pin_p_out) else $error("master pulse without request");
   chk_period_len: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !cfg_q.repeater |-> half_end == 13'h0004 + {1'b0, cfg_q.period, 1'b0})
      else $error("period ratio wrong");
   chk_burst_end: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state_q == ST_LOW && half_done && cfg_q.pulsed && rem_q == 4'h1 && !start && cfg_q.en)
      |=> state_q == ST_IDLE) else $error("burst overran its count");
   chk_cnt_reset: assert property (@(posedge clk_in)
      $past(sys_rst_in) |-> cfg_q.pulse_cnt == 4'h4) else $error("pulse count reset wrong");
   chk_dac_sum: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      8'(delay_dac_out.dac1) + 8'(delay_dac_out.dac2) + 8'(delay_dac_out.dac3)
      + 8'(delay_dac_out.dac4) == 8'h3F) else $error("delay words do not sum to 63");
   chk_diff_out: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      out_b_pin_n_out == !out_b_pin_p_out) else $error("output pair not complementary");
   chk_rpt_align: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      s_idle_rpt ##0 s_enter_high |-> $past(out_tick)) else $error("repeat not on output clock");
   chk_high_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state_q == ST_HIGH && !half_done && !start && cfg_q.en) |=> state_q == ST_HIGH)
      else $error("high phase cut short");

endmodule : srg_sysref_gen

//--- sim/srg_req_drv.sv
// request pin driver standing for the party outside the generator
`timescale 1ns/1ns
module srg_req_drv (
   input  wire logic clk_in,
   input  wire logic set_in,
   input  wire logic level_in,
   input  wire logic toggle_in,
   output logic      pin_out
);
   // ------------------------------------------------------------
   // pin state, always driven so the level is never left floating
   // ------------------------------------------------------------
   initial pin_out = 1'b0;
   always @(posedge clk_in) begin
      if (toggle_in) begin
         pin_out <= ~pin_out;
      end else if (set_in) begin
         pin_out <= level_in;
      end
   end
endmodule : srg_req_drv

//--- sim/tb.sv
// self-checking bench for the ref_pulsed_select generator
`timescale 1ns/1ns
module tb;
   import srg_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        clk_in;
   logic        sys_rst_in;
   srg_bus_t    bus;
   logic [15:0] rdata;
   logic        req;
   logic        p;
   logic        n;
   srg_dac_t    dac;
   logic        cfg_err;
   logic        rq_set;
   logic        rq_lvl;
   logic        rq_tog;
   logic [15:0] rd_v;
   logic [23:0] exp_dac;
   int          failures;
   int          samples_checked;
   int          k;
   int          c;
   int          pre;
   int          half;
   int          len;
   int          edges;
   int          cnt;
   srg_sysref_gen u_srg_sysref_gen (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus),
      .bus_rdata_out(rdata), .ref_request_pin_in(req), .out_b_pin_p_out(p), .out_b_pin_n_out(n),
      .delay_dac_out(dac), .cfg_error_out(cfg_err));
   srg_req_drv u_srg_req_drv (.clk_in(clk_in), .set_in(rq_set), .level_in(rq_lvl),
      .toggle_in(rq_tog), .pin_out(req));
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   initial begin
      #4000000;
      failures++;
      stop_test();
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic step(input int m);
      repeat (m) @(posedge clk_in);
      #1;
   endtask : step
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic drv(input logic s, input logic l, input logic t);
      @(posedge clk_in);
      rq_set <= s;
      rq_lvl <= l;
      rq_tog <= t;
      @(posedge clk_in);
      rq_set <= 1'b0;
      rq_tog <= 1'b0;
   endtask : drv
   task automatic wait_p(input logic v, input int lim);
      k = 0;
      while (p !== v && k < lim) begin
         step(1);
         k++;
      end
      if (p !== v) begin
         failures++;
         stop_test();
      end
   endtask : wait_p
   task automatic run_len(input logic v, output int l);
      l = 0;
      while (p === v && l < 5000) begin
         chk("n", n, !p);
         step(1);
         l++;
      end
   endtask : run_len
   task automatic count_rise(input int w, output int e);
      logic last;
      e = 0;
      last = p;
      repeat (w) begin
         step(1);
         if (p === 1'b1 && last !== 1'b1) e++;
         last = p;
      end
   endtask : count_rise
   function automatic logic [15:0] ctrl(input logic e, input logic r, input logic pl, input int cn, input int pr);
      return {5'h00, pr[2:0], cn[3:0], 1'b0, pl, r, e};
   endfunction : ctrl
   // sliding model: 63 moves one step per code from one word to the next
   function automatic logic [23:0] dac_model(input int cd);
      int w[4];
      int t;
      t = cd + 27;
      w = '{0, 0, 0, 0};
      w[(t / 63) % 4] = 63 - t % 63;
      w[(t / 63 + 1) % 4] = t % 63;
      return {w[3][5:0], w[2][5:0], w[1][5:0], w[0][5:0]};
   endfunction : dac_model
   // ------------------------------------------------------------
   // main sequence; phase-sync mode is taken as on throughout
   // ------------------------------------------------------------
   initial begin
      logic [7:0]  ra[7];
      logic [15:0] rv[7];
      int          dc[6];
      void'($urandom(41718));
      failures = 0;
      samples_checked = 0;
      bus = '0;
      rq_set = 1'b0;
      rq_lvl = 1'b0;
      rq_tog = 1'b0;
      ra = '{ADDR_CTRL, ADDR_PERIOD, ADDR_DELAY, ADDR_ROUTE, ADDR_DAC_LO, ADDR_DAC_HI, 8'h07};
      rv = '{16'h0140, 16'h0000, 16'h0000, 16'h0015, 16'h06E4, 16'h0000, 16'h0000};
      dc = '{0, 36, 37, 99, 162, 247};
      sys_rst_in = 1'b1;
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      step(1);
      chk("p_rst", {n, p}, 2'h2);
      for (int i = 0; i < 7; i++) begin
         rd(ra[i], rd_v);
         chk("reset_reg", rd_v, rv[i]);
      end
      // delay words, table rows then random legal codes
      for (int i = 0; i < 12; i++) begin
         c = (i < 6) ? dc[i] : int'($urandom % 248);
         exp_dac = dac_model(c);
         wr(ADDR_DELAY, 16'(c));
         step(2);
         chk("dac", dac, exp_dac);
         chk("dac_sum", 32'(dac.dac1) + 32'(dac.dac2) + 32'(dac.dac3) + 32'(dac.dac4), 63);
         rd(ADDR_DAC_LO, rd_v);
         chk("dac_lo", rd_v, {4'h0, exp_dac[11:0]});
      end
      wr(ADDR_DELAY, 16'h00F8);
      step(2);
      chk("dac_keep", dac, exp_dac);
      chk("cfg_dly", cfg_err, 1);
      wr(ADDR_DELAY, 16'h0000);
      // invalid predivider codes raise the error flag
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CTRL, ctrl(0, 0, 0, 4, i));
         step(3);
         rd(ADDR_STATUS, rd_v);
         chk("cfg_pre", {cfg_err, rd_v[2]}, (i == 1 || i == 2 || i == 4) ? 2'h0 : 2'h3);
      end
      // master continuous; enable only with output B on sysref
      drv(1'b1, 1'b1, 1'b0);
      for (int i = 0; i < 3; i++) begin
         pre = 1 << i;
         c = int'($urandom % 3);
         half = (4 + 2 * c) * ((i == 1) ? 4 : 2) * pre;
         wr(ADDR_CTRL, 16'h0000);
         wr(ADDR_ROUTE, (i == 1) ? 16'h0119 : 16'h0019);
         wr(ADDR_PERIOD, 16'(c));
         wr(ADDR_CTRL, ctrl(1, 0, 0, 4, pre));
         wait_p(1'b1, 3000);
         wait_p(1'b0, 3000);
         wait_p(1'b1, 3000);
         run_len(1'b1, len);
         chk("high", len, half);
         run_len(1'b0, len);
         chk("low", len, half);
         drv(1'b1, 1'b0, 1'b0);
         step(100);
         count_rise(300, edges);
         chk("gated", {edges[7:0], p}, 9'h000);
         drv(1'b1, 1'b1, 1'b0);
         wait_p(1'b1, 3000);
      end
      // master pulsed bursts, period 16 clocks
      wr(ADDR_PERIOD, 16'h0000);
      foreach (dc[i]) begin
         cnt = (i == 0) ? 0 : ((i == 1) ? 15 : int'($urandom % 16));
         wr(ADDR_CTRL, 16'h0000);
         drv(1'b1, 1'b0, 1'b0);
         wr(ADDR_CTRL, ctrl(1, 0, 1, cnt, 1));
         step(20);
         drv(1'b1, 1'b1, 1'b0);
         count_rise(cnt * 32 + 200, edges);
         chk("burst", edges, cnt);
         rd(ADDR_STATUS, rd_v);
         chk("burst_idle", rd_v, 16'h0100);
      end
      // repeater bursts on alternating pin edges, half period (2+code)*2 clocks
      c = int'($urandom % 3);
      wr(ADDR_PERIOD, 16'(c));
      for (int i = 0; i < 4; i++) begin
         cnt = 1 << i;
         wr(ADDR_CTRL, 16'h0000);
         wr(ADDR_CTRL, ctrl(1, 1, 1, cnt, 1));
         step(10);
         drv(1'b0, 1'b0, 1'b1);
         wait_p(1'b1, 500);
         run_len(1'b1, len);
         chk("rpt_high", len, (2 + c) * 2);
         count_rise(cnt * 4 * (2 + c) + 200, edges);
         chk("rpt_burst", edges, cnt - 1);
      end
      stop_test();
   end
endmodule : tb
